// ### inc/psrpc_pkg.sv
// Constants for the pipelined SRAM pin control block
package psrpc_pkg;
  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 16;
  localparam int LANES       = 2;
  localparam int LANE_W      = 8;
  localparam int SLEEP_CYC   = 2;
  localparam logic [1:0] SLEEP_CNT_INIT = 2'h0;
  localparam logic BURST_LINEAR = 1'b0;
  typedef enum logic [1:0] {
    PSRPC_AWAKE    = 2'b00,
    PSRPC_ENTERING = 2'b01,
    PSRPC_ASLEEP   = 2'b11,
    PSRPC_LEAVING  = 2'b10
  } psrpc_sleep_e;
endpackage

// ### rtl/psrpc_sram_pins.sv
// Pipelined SRAM control, data pin turnaround, sleep and burst logic
//
// Behaviour
// (R1) First select active low, rising edge
// (R2) Second select active high, rising edge
// (R3) Third select active low, combined selection
// (R4) Output gate low allows data drive
// (R5) Clock qualify high freezes all state; sleep sequencer, burst strap and output gate sampling keep running
// (R6) Clock qualify never deselects the device
// (R7) Sleep request enters state, keeps contents
// (R8) Controller holds sleep low normally
// (R9) Write data captured on rising edge
// (R10) Read returns location addressed at start
// (R11) Float on write, after deselect, deselected
// (R12) Parity lanes written per byte lane
// (R13) Strap low linear, high interleaved
// (R14) Advance high increments, low loads address
// (R15) Write strobe low begins a write
// (R16) Read data driven edge after address
// (R17) Sleep entry and exit take two cycles
`timescale 1ns/1ps
`default_nettype none
module psrpc_sram_pins
  import psrpc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // Control pins
  input  wire logic                 select_low_first,
  input  wire logic                 select_high_second,
  input  wire logic                 select_low_third,
  input  wire logic                 clock_qualify_n,
  input  wire logic                 advance_or_load,
  input  wire logic                 write_n,
  input  wire logic [LANES-1:0]     byte_lane_write_n,
  input  wire logic                 output_gate_n,
  input  wire logic                 sleep_request,
  input  wire logic                 burst_mode,
  input  wire logic [AW-1:0]        address,
  // Data pins
  input  wire logic [DW-1:0]        dataIn,
  output logic      [DW-1:0]        dataOut,
  output logic      [DW-1:0]        dataOe,
  input  wire logic [LANES-1:0]     parity_lines_in,
  output logic      [LANES-1:0]     parity_lines_out,
  output logic      [LANES-1:0]     parity_lines_oe,
  // Status
  output logic                      asleep
);
  import psrpc_pkg::*;

  localparam int DEPTH = 1 << AW;
  localparam int WW    = DW + LANES;

  logic [WW-1:0]  mem [DEPTH];
  logic [AW-1:0]  addr_r;
  logic [1:0]     burstBase_r;
  logic [1:0]     burstCnt_r;
  logic           accWrite_r;
  logic           accValid_r;
  logic           wrPhase_r;
  logic [AW-1:0]  wrAddr_r;
  logic           rdPhase_r;
  logic [DW-1:0]  rdData_r;
  logic [LANES-1:0] rdPar_r;
  logic           driveEn_r;
  psrpc_sleep_e   sleep_r;
  logic [1:0]     sleepCnt_r;
  logic           modeLinear_r;

  logic           qual;
  logic           selected;
  logic           loadNew;
  logic [1:0]     burstLow;
  logic [AW-1:0]  curAddr;
  logic           awake;

  assign awake    = (sleep_r == PSRPC_AWAKE);
  assign qual     = !clock_qualify_n && awake; // R5 R6
  assign selected = !select_low_first && select_high_second && !select_low_third; // R1 R2 R3
  assign loadNew  = qual && !advance_or_load; // R14

  // Burst order; interleave uses xor of start offset
  always_comb begin
    if (modeLinear_r) begin
      burstLow = burstBase_r + burstCnt_r;
    end else begin
      burstLow = burstBase_r ^ burstCnt_r;
    end
  end
  assign curAddr = {addr_r[AW-1:2], burstLow};

  // Strap sampled after reset release, never under reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeLinear_r <= 1'b0;
    end else begin
      modeLinear_r <= (burst_mode == BURST_LINEAR); // R13
    end
  end

  // Address and burst counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_r      <= '0;
      burstBase_r <= 2'h0;
      burstCnt_r  <= 2'h0;
      accWrite_r  <= 1'b0;
      accValid_r  <= 1'b0;
    end else if (loadNew) begin
      addr_r      <= address; // R14
      burstBase_r <= address[1:0];
      burstCnt_r  <= 2'h0;
      accValid_r  <= selected; // R1 R2 R3
      accWrite_r  <= !write_n; // R15
    end else if (qual) begin
      burstCnt_r  <= burstCnt_r + 2'h1; // R14
    end
  end

  // Pipeline stage: write data phase or read output follows access edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPhase_r <= 1'b0;
      rdPhase_r <= 1'b0;
      wrAddr_r  <= '0;
    end else if (qual) begin
      wrPhase_r <= accValid_r && accWrite_r; // R11
      rdPhase_r <= accValid_r && !accWrite_r;
      wrAddr_r  <= curAddr;
    end
  end

  // Write capture, parity per lane
  always_ff @(posedge core_clk) begin
    if (qual && wrPhase_r) begin
      for (int i = 0; i < LANES; i++) begin
        if (!byte_lane_write_n[i]) begin
          mem[wrAddr_r][i*LANE_W +: LANE_W] <= dataIn[i*LANE_W +: LANE_W]; // R9
          mem[wrAddr_r][DW+i]               <= parity_lines_in[i]; // R12
        end
      end
    end
  end

  // Read output register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r <= '0;
      rdPar_r  <= '0;
    end else if (qual && accValid_r && !accWrite_r) begin
      rdData_r <= mem[curAddr][DW-1:0]; // R10 R16
      rdPar_r  <= mem[curAddr][WW-1:DW]; // R12
    end
  end
  assign dataOut          = rdData_r;
  assign parity_lines_out = rdPar_r;

  // Drive enable registered; gate sampled each edge as flops feed pins
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      driveEn_r <= 1'b0;
    end else begin
      // Frozen edges keep the phase already on the pins; a slot loaded
      // while deselected never drives, so emerging needs no extra mask
      driveEn_r <= !output_gate_n && awake && (qual ? (accValid_r && !accWrite_r)
                   : rdPhase_r); // R4 R11 R16
    end
  end
  assign dataOe          = {DW{driveEn_r}};
  assign parity_lines_oe = {LANES{driveEn_r}}; // R12

  // Sleep sequencing, two cycles each way
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_r    <= PSRPC_AWAKE;
      sleepCnt_r <= SLEEP_CNT_INIT;
    end else begin
      case (sleep_r)
        PSRPC_AWAKE: begin
          if (sleep_request) begin // R7 R8
            sleep_r    <= PSRPC_ENTERING;
            sleepCnt_r <= 2'h1;
          end
        end
        PSRPC_ENTERING: begin
          if (sleepCnt_r == 2'(SLEEP_CYC - 1)) begin
            sleep_r <= PSRPC_ASLEEP; // R17
          end else begin
            sleepCnt_r <= sleepCnt_r + 2'h1;
          end
        end
        PSRPC_ASLEEP: begin
          if (!sleep_request) begin
            sleep_r    <= PSRPC_LEAVING;
            sleepCnt_r <= 2'h1;
          end
        end
        PSRPC_LEAVING: begin
          if (sleepCnt_r == 2'(SLEEP_CYC - 1)) begin
            sleep_r <= PSRPC_AWAKE; // R17
          end else begin
            sleepCnt_r <= sleepCnt_r + 2'h1;
          end
        end
        default: sleep_r <= PSRPC_AWAKE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asleep <= 1'b0;
    end else begin
      // Flag rises together with the state, not a cycle behind it
      asleep <= ((sleep_r == PSRPC_ENTERING) && (sleepCnt_r == 2'(SLEEP_CYC - 1))) ||
                ((sleep_r == PSRPC_ASLEEP) && sleep_request); // R7 R17
    end
  end

  sequence s_readStart;
    qual && accValid_r && !accWrite_r;
  endsequence

  chk_read_drive_gate: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
    s_readStart ##0 !output_gate_n |=> driveEn_r)
    else $error("read data not driven after address edge");
  chk_write_float: assert property (@(posedge core_clk) disable iff (sys_rst) // R11
    wrPhase_r |-> !driveEn_r)
    else $error("drive during write data phase");
  chk_gate_float: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    output_gate_n |=> !driveEn_r)
    else $error("drive while output gate high");
  chk_freeze_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
    clock_qualify_n |=> $stable(addr_r) && $stable(burstCnt_r))
    else $error("state moved while clock unqualified");
  chk_load_addr: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
    loadNew |=> addr_r == $past(address) && burstCnt_r == 2'h0)
    else $error("address not loaded");
  chk_advance_cnt: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
    qual && advance_or_load |=> burstCnt_r == $past(burstCnt_r) + 2'h1)
    else $error("burst counter not advanced");
  chk_select_decode: assert property (@(posedge core_clk) disable iff (sys_rst) // R1 R2 R3
    loadNew |=> accValid_r == $past(selected))
    else $error("selection decode wrong");
  chk_sleep_entry: assert property (@(posedge core_clk) disable iff (sys_rst) // R17
    sleep_r == PSRPC_AWAKE && sleep_request |=> ##1 sleep_r == PSRPC_ASLEEP)
    else $error("sleep entry not two cycles");
  chk_sleep_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // R7
    sleep_r == PSRPC_AWAKE && sleep_request |=> ##1 asleep)
    else $error("sleep flag late on entry");
  chk_strap_mode: assert property (@(posedge core_clk) disable iff (sys_rst) // R13
    1'b1 |=> modeLinear_r == !$past(burst_mode))
    else $error("burst strap not followed");
endmodule
`default_nettype wire

// ### tb/pipelined_sram_pin_control_test.sv
// Self-checking bench for the pipelined SRAM pin control block
`timescale 1ns/1ps
`default_nettype none
module pipelined_sram_pin_control_test;
  import psrpc_pkg::*;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [2:0] OFF = 3'h6;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clock_qualify_n = 1'b0;
  logic output_gate_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_mode = BURST_LINEAR;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [17:0] mdl[logic [17:0]];
  wire logic select_low_first, select_high_second, select_low_third, advance_or_load;
  wire logic write_n, asleep;
  wire logic [1:0] byte_lane_write_n, parity_lines_in, parity_lines_out, parity_lines_oe;
  wire logic [17:0] address;
  wire logic [15:0] dataIn, dataOut, dataOe;
  psrpc_sram_pins dut (
    .core_clk, .sys_rst, .select_low_first, .select_high_second, .select_low_third,
    .clock_qualify_n, .advance_or_load, .write_n, .byte_lane_write_n, .output_gate_n,
    .sleep_request, .burst_mode, .address, .dataIn, .dataOut, .dataOe, .parity_lines_in,
    .parity_lines_out, .parity_lines_oe, .asleep
  );
  psrpc_ctrl_model ctrl (
    .core_clk, .select_low_first, .select_high_second, .select_low_third,
    .advance_or_load, .write_n, .byte_lane_write_n, .address, .dataIn, .parity_lines_in
  );
  always #20 core_clk = ~core_clk;
  function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] bwn);
    logic [17:0] m;
    m = {~bwn[1], ~bwn[0], {8{~bwn[1]}}, {8{~bwn[0]}}};
    return (n & m) | (o & ~m);
  endfunction
  function automatic logic [17:0] seq(input logic [17:0] a, input int k, input logic m);
    return m ? (a ^ 18'(k)) : {a[17:2], 2'(a[1:0] + 2'(k))};
  endfunction
  task automatic chk(input logic [17:0] e, input logic oe);
    totalChecks++;
    if (dataOe !== {DATA_W{oe}} || parity_lines_oe !== {LANES{oe}} ||
        (oe && {parity_lines_out, dataOut} !== e)) begin
      failCount++;
      $display("unexpected output at %0t: got %h want %h", $time, {parity_lines_out, dataOut}, e);
    end
  endtask
  task automatic flag(input logic v);
    totalChecks++;
    if (asleep !== v) begin
      failCount++;
      $display("unexpected sleep flag at %0t", $time);
    end
  endtask
  task automatic go(input logic [2:0] s, input logic adv, input logic [17:0] a);
    ctrl.cyc(s, adv, 1'b1, a, 2'h3, 1'b0, '0);
  endtask
  task automatic wr(input logic [17:0] a, input logic [17:0] d, input logic [1:0] bwn);
    ctrl.cyc(ON, 1'b0, 1'b0, a, 2'h3, 1'b0, '0);
    ctrl.cyc(OFF, 1'b0, 1'b1, a, 2'h3, 1'b0, '0);
    chk('0, 1'b0);
    ctrl.cyc(OFF, 1'b0, 1'b1, a, bwn, 1'b1, d);
    mdl[a] = merge(mdl.exists(a) ? mdl[a] : '0, d, bwn);
  endtask
  task automatic rd(input logic [2:0] s, input logic [17:0] a, input logic [17:0] e,
                    input logic oe);
    go(s, 1'b0, a);
    go(OFF, 1'b0, a);
    chk(e, oe);
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run needs under a hundred cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failCount++;
      stopTest();
    end
  end
  initial begin
    logic [17:0] a;
    void'($urandom(23));
    repeat (5) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = 18'($urandom);
      wr(a, 18'($urandom), 2'h0);
      rd(ON, a, mdl[a], 1'b1);
    end
    for (int k = 1; k < 3; k++) begin
      wr(a, 18'($urandom), 2'(k));
      rd(ON, a, mdl[a], 1'b1);
    end
    output_gate_n = 1'b1;
    rd(ON, a, '0, 1'b0);
    output_gate_n = 1'b0;
    for (int k = 0; k < 3; k++) rd(ON ^ 3'(1 << k), a, '0, 1'b0);
    go(ON, 1'b0, a);
    clock_qualify_n = 1'b1;
    repeat (3) begin
      go(OFF, 1'b0, a);
      chk('0, 1'b0);
    end
    clock_qualify_n = 1'b0;
    go(OFF, 1'b0, a);
    chk(mdl[a], 1'b1);
    clock_qualify_n = 1'b1;
    go(OFF, 1'b0, a);
    chk(mdl[a], 1'b1);
    clock_qualify_n = 1'b0;
    a = {16'($urandom), 2'h0};
    for (int k = 0; k < 4; k++) wr(a | 18'(k), 18'($urandom), 2'h0);
    for (int m = 0; m < 2; m++) begin
      burst_mode = m[0];
      go(ON, 1'b0, a | 18'h1);
      for (int k = 1; k < 4; k++) begin
        go(ON, 1'b1, a);
        chk(mdl[seq(a | 18'h1, k - 1, m[0])], 1'b1);
      end
      go(OFF, 1'b0, a);
      chk(mdl[seq(a | 18'h1, 3, m[0])], 1'b1);
    end
    sleep_request = 1'b1;
    @(posedge core_clk);
    #1;
    flag(1'b0);
    @(posedge core_clk);
    #1;
    flag(1'b1);
    sleep_request = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    flag(1'b0);
    rd(ON, a, mdl[a], 1'b1);
    stopTest();
  end
endmodule
`default_nettype wire

// ### tb/psrpc_ctrl_model.sv
// Memory controller model that drives the SRAM control and data pins
`timescale 1ns/1ps
`default_nettype none
module psrpc_ctrl_model
  import psrpc_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Control pins
  output logic                   select_low_first,
  output logic                   select_high_second,
  output logic                   select_low_third,
  output logic                   advance_or_load,
  output logic                   write_n,
  output logic [LANES-1:0]       byte_lane_write_n,
  output logic [ADDR_W-1:0]      address,
  // Data and parity pins
  output logic [DATA_W-1:0]      dataIn,
  output logic [LANES-1:0]       parity_lines_in
);
  logic        drv = 1'b0;
  logic [17:0] wd = '0;
  // Released lines show the inverse, so stale data never matches
  assign {parity_lines_in, dataIn} = drv ? wd : ~wd;
  initial {select_low_first, select_high_second, select_low_third} = 3'h6;
  initial {advance_or_load, write_n, byte_lane_write_n, address} = {2'h1, 2'h3, 18'h0};
  // One clock of activity, entered just after a rising edge
  task automatic cyc(input logic [2:0] s, input logic adv, input logic wn,
                     input logic [17:0] a, input logic [1:0] bwn, input logic dv,
                     input logic [17:0] d);
    {select_low_first, select_high_second, select_low_third} = s;
    advance_or_load = adv;
    write_n = wn;
    address = a;
    byte_lane_write_n = bwn;
    drv = dv;
    if (dv) wd = d;
    @(posedge core_clk);
    #1;
  endtask
endmodule
`default_nettype wire
